// ==== verilog/vlh_defines.vh ====
// Offsets, field positions, reset values and timing constants of the variable-latency host port
`ifndef VLH_DEFINES_VH
`define VLH_DEFINES_VH
// Register byte offsets on the Avalon-MM slave
`define VLH_REG_CTRL 5'h00
`define VLH_REG_ADDR 5'h04
`define VLH_REG_WDATA 5'h08
`define VLH_REG_RDATA 5'h0c
`define VLH_REG_TIMING 5'h10
`define VLH_REG_WIDTH 5'h14
`define VLH_REG_STATUS 5'h18
// Control register fields
`define VLH_CTRL_GO 0
`define VLH_CTRL_READ 1
`define VLH_CTRL_SEL_LO 2
`define VLH_CTRL_SEL_HI 4
`define VLH_CTRL_SIZE_LO 5
`define VLH_CTRL_SIZE_HI 6
`define VLH_CTRL_BIG 7
`define VLH_CTRL_BURST_LO 8
`define VLH_CTRL_BURST_HI 15
// Transfer size codes
`define VLH_SIZE_BYTE 2'h0
`define VLH_SIZE_WORD 2'h1
`define VLH_SIZE_DWORD 2'h2
// Timing register fields
`define VLH_TIM_FIRST_LO 0
`define VLH_TIM_FIRST_HI 4
`define VLH_TIM_GAP_LO 8
`define VLH_TIM_GAP_HI 12
// Status register fields
`define VLH_STAT_BUSY 0
`define VLH_STAT_DONE 1
`define VLH_STAT_ERR 2
// Reset values
`define VLH_TIMING_RST 13'h0102
`define VLH_WIDTH_RST 6'h00
// Ready-stretching selects and the sample run that counts as ready
`define VLH_RDY_SEL_LO 3'h3
`define VLH_RDY_SEL_HI 3'h5
`define VLH_RDY_SAMPLES 2'h3
// Timing: the memory clock may not exceed the port maximum
`define VLH_REF_PERIOD_NS 8
`define VLH_BUS_CLK_MAX_MHZ 50
`define VLH_HALF_DIV ((1000 / (2 * `VLH_BUS_CLK_MAX_MHZ) + `VLH_REF_PERIOD_NS - 1) / `VLH_REF_PERIOD_NS)
`endif

// ==== verilog/vlh_host_port.v ====
// Host controller driving a variable-latency IO bus, ordered over an Avalon-MM slave
//
// Contract
// (RL1) Host uses 26-bit address, 32-bit data bus
// (RL2) Six selects, each 16 or 32 bits
// (RL3) Only selects three to five honour ready
// (RL4) Four lane strobes; 16-bit uses lanes 0,1
// (RL5) Little or big endian byte ordering
// (RL6) Start: drive address, assert one select low
// (RL7) Lane strobes encode dword, word or byte
// (RL8) Read: output enable low; write: write enable low
// (RL9) Device holds ready high to stretch
// (RL10) Output enable two cycles after select
// (RL11) Strobe min first+1 cycles; sample two before
// (RL12) Ready after three consecutive half-cycle samples
// (RL13) Latch at fall, release at rise
// (RL14) Strobe high gap+1 cycles between beats
// (RL15) Select and lanes held one cycle after
// (RL16) Bursts keep select low, strobe repeats
// (RL17) Device waits host until data ready
// (RL18) Device wait polarity and drive from straps
// (RL19) Device routes register or buffer access
// (RL20) Device bus clock up to 50 MHz
// (RL21) Device keeps ready steady three samples
// (RL22) Device starts each access not ready
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`include "vlh_defines.vh"
module vlh_host_port #(
  parameter ADDR_W = 26, // Bus address width
  parameter DATA_W = 32, // Bus data width
  parameter NSEL = 6, // Number of device selects
  parameter HALF_DIV = `VLH_HALF_DIV // Reference cycles per half memory cycle
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg host_port_clock,
  output reg [ADDR_W-1:0] bus_address,
  output reg [DATA_W-1:0] bus_data_out,
  input wire [DATA_W-1:0] bus_data_in,
  output reg bus_data_oe_n,
  output reg [NSEL-1:0] device_select_n,
  output reg [3:0] byte_lane_strobe_n,
  output reg output_enable_n,
  output reg write_enable_n,
  input wire ready_n
);
  // One-hot sequencer states
  localparam ST_IDLE = 5'h01;
  localparam ST_SETUP = 5'h02;
  localparam ST_STROBE = 5'h04;
  localparam ST_GAP = 5'h08;
  localparam ST_HOLD = 5'h10;
  reg [4:0] state; // Sequencer state
  reg [7:0] hcnt; // Half-cycle divider count
  reg [7:0] cyc; // Memory cycles in the current phase
  reg [7:0] beats; // Beats left after the current one
  reg [1:0] scnt; // Consecutive ready samples
  reg got; // Good sample at a rise after two in a row seen
  reg latched; // Read data taken this beat
  reg moved; // Address stepped in this gap
  reg [15:0] ctrl; // Order: direction, select, size, endian, burst
  reg [31:0] addr_reg; // Start address
  reg [31:0] wdata; // Write data
  reg [31:0] rdata; // Last read data, raw lanes
  reg [12:0] timing; // First-access and gap counts
  reg [5:0] width32; // 1 marks a 32-bit select
  reg busy; // Transfer in flight
  reg done; // Sticky completion
  reg err; // Sticky refused order
  reg go; // Pending start
  reg ack; // Avalon answer cycle
  reg rdy1, rdy2, rdy3; // Ready pin synchroniser
  reg rdy_q; // Filtered ready pin level
  reg [DATA_W-1:0] din1, din2, din3; // Data pin synchroniser
  reg [3:0] next_lanes; // Lane mask for the order
  reg [DATA_W-1:0] next_wbus; // Write data placed on lanes
  reg refuse; // Order cannot run
  wire half_tick = (hcnt == HALF_DIV[7:0] - 8'h01); // Half memory cycle boundary
  wire rise_en = half_tick & ~host_port_clock; // Memory clock goes high
  wire fall_en = half_tick & host_port_clock; // Memory clock goes low
  wire [2:0] sel = ctrl[`VLH_CTRL_SEL_HI:`VLH_CTRL_SEL_LO];
  wire [1:0] size = ctrl[`VLH_CTRL_SIZE_HI:`VLH_CTRL_SIZE_LO];
  wire big = ctrl[`VLH_CTRL_BIG];
  wire rd = ctrl[`VLH_CTRL_READ];
  wire [4:0] first_cnt = timing[`VLH_TIM_FIRST_HI:`VLH_TIM_FIRST_LO];
  wire [4:0] gap_cnt = timing[`VLH_TIM_GAP_HI:`VLH_TIM_GAP_LO];
  wire wide = |(width32 & (6'h01 << sel)); // Selected bus is 32 bits wide; unused codes narrow
  wire honour = (sel >= `VLH_RDY_SEL_LO) && (sel <= `VLH_RDY_SEL_HI); // RL3
  wire rdy_eff = honour ? ~rdy_q : 1'b1; // Ready low means go on, RL9
  wire samp_on = ({1'b0, cyc} + 9'd2 >= {4'h0, first_cnt} + 9'd1); // RL11
  wire min_met = (cyc >= {3'h0, first_cnt}); // Strobe held first+1 cycles, RL11
  wire [31:0] step = (size == `VLH_SIZE_DWORD) ? 32'h4 :
                     (size == `VLH_SIZE_WORD) ? 32'h2 : 32'h1;
  // Lane mask, data placement and refusal for the order in hand
  always @* begin
    next_lanes = 4'hf;
    next_wbus = wdata;
    refuse = (sel >= NSEL[2:0]);
    case (size)
      `VLH_SIZE_BYTE: begin
        // One low lane picks the byte; big endian mirrors lanes, RL5 RL7
        next_lanes = wide ? (4'h1 << (big ? ~addr_reg[1:0] : addr_reg[1:0])) :
                     ((addr_reg[0] ^ big) ? 4'h2 : 4'h1); // RL4
        next_wbus = {4{wdata[7:0]}};
      end
      `VLH_SIZE_WORD: begin
        // Lanes one and zero form a word on a narrow bus, RL7
        next_lanes = (wide && (addr_reg[1] ^ big)) ? 4'hc : 4'h3;
        next_wbus = big ? {2{wdata[7:0], wdata[15:8]}} : {2{wdata[15:0]}}; // RL5
      end
      `VLH_SIZE_DWORD: begin
        // All four lanes, as set at the top; a narrow bus cannot carry it, RL4
        next_wbus = big ? {wdata[7:0], wdata[15:8], wdata[23:16], wdata[31:24]} : wdata;
        if (!wide) refuse = 1'b1;
      end
      default: refuse = 1'b1;
    endcase
  end
  // Memory clock divider; every slower event keys off its half ticks, RL20
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      hcnt <= 8'h00;
      host_port_clock <= 1'b0;
    end else if (half_tick) begin
      hcnt <= 8'h00;
      host_port_clock <= ~host_port_clock;
    end else begin
      hcnt <= hcnt + 8'h01;
    end
  end
  // Pin synchronisers; ready counts only when the second and third stage agree
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rdy1 <= 1'b1;
      rdy2 <= 1'b1;
      rdy3 <= 1'b1;
      rdy_q <= 1'b1;
      din1 <= {DATA_W{1'b0}};
      din2 <= {DATA_W{1'b0}};
      din3 <= {DATA_W{1'b0}};
    end else begin
      rdy1 <= ready_n;
      rdy2 <= rdy1;
      rdy3 <= rdy2;
      if (rdy2 == rdy3) rdy_q <= rdy3;
      din1 <= bus_data_in;
      din2 <= din1;
      din3 <= din2;
    end
  end
  // Avalon-MM slave: one wait cycle, then the answer at the edge waitrequest is low
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl <= 16'h0000;
      addr_reg <= 32'h0000_0000;
      wdata <= 32'h0000_0000;
      timing <= `VLH_TIMING_RST;
      width32 <= `VLH_WIDTH_RST;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack);
      if (avs_read && !ack) begin
        // Read data stand from the answer cycle onward
        case (avs_address)
          `VLH_REG_CTRL: avs_readdata <= {16'h0000, ctrl[15:1], 1'b0};
          `VLH_REG_ADDR: avs_readdata <= addr_reg;
          `VLH_REG_WDATA: avs_readdata <= wdata;
          `VLH_REG_RDATA: avs_readdata <= rdata;
          `VLH_REG_TIMING: avs_readdata <= {19'h00000, timing};
          `VLH_REG_WIDTH: avs_readdata <= {26'h0000000, width32};
          `VLH_REG_STATUS: avs_readdata <= {29'h00000000, err, done, busy};
          default: avs_readdata <= 32'h0000_0000; // Unmapped reads as zero
        endcase
      end
      if (avs_write && ack && !busy) begin
        // Order registers are frozen while a transfer runs
        case (avs_address)
          `VLH_REG_CTRL: ctrl <= avs_writedata[15:0];
          `VLH_REG_ADDR: addr_reg <= avs_writedata;
          `VLH_REG_WDATA: wdata <= avs_writedata;
          `VLH_REG_TIMING: timing <= avs_writedata[12:0];
          `VLH_REG_WIDTH: width32 <= avs_writedata[5:0]; // RL2
          default: ;
        endcase
      end
    end
  end
  // Bus sequencer
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cyc <= 8'h00;
      beats <= 8'h00;
      scnt <= 2'h0;
      got <= 1'b0;
      latched <= 1'b0;
      moved <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      go <= 1'b0;
      rdata <= 32'h0000_0000;
      bus_address <= {ADDR_W{1'b0}};
      bus_data_out <= {DATA_W{1'b0}};
      bus_data_oe_n <= 1'b1;
      device_select_n <= {NSEL{1'b1}};
      byte_lane_strobe_n <= 4'hf;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
    end else begin
      // Software clears sticky flags with ones; a same-cycle event still sets them
      if (avs_write && ack && avs_address == `VLH_REG_STATUS) begin
        if (avs_writedata[`VLH_STAT_DONE]) done <= 1'b0;
        if (avs_writedata[`VLH_STAT_ERR]) err <= 1'b0;
      end
      // A go bit while idle queues the order
      if (avs_write && ack && !busy && avs_address == `VLH_REG_CTRL &&
          avs_writedata[`VLH_CTRL_GO]) begin
        go <= 1'b1;
        busy <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (go && rise_en) begin
            go <= 1'b0;
            if (refuse) begin
              err <= 1'b1;
              busy <= 1'b0;
            end else begin
              // Address and one select go out together, RL1 RL6
              bus_address <= addr_reg[ADDR_W-1:0];
              device_select_n <= ~({{(NSEL-1){1'b0}}, 1'b1} << sel); // RL6
              byte_lane_strobe_n <= ~next_lanes; // RL7
              bus_data_out <= next_wbus;
              bus_data_oe_n <= rd;
              beats <= ctrl[`VLH_CTRL_BURST_HI:`VLH_CTRL_BURST_LO];
              cyc <= 8'h00;
              state <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          if (rise_en) begin
            if (cyc == 8'h01) begin
              // Second rise after the select: strobe goes low, RL10 RL8
              output_enable_n <= ~rd;
              write_enable_n <= rd;
              cyc <= 8'h00;
              scnt <= 2'h0;
              got <= 1'b0;
              latched <= 1'b0;
              state <= ST_STROBE;
            end else begin
              cyc <= cyc + 8'h01;
            end
          end
        end
        ST_STROBE: begin
          // Sample every half cycle in the window; a miss restarts the run, RL12
          if ((rise_en || fall_en) && samp_on && !got) begin
            if (!rdy_eff) begin
              scnt <= 2'h0;
            end else if (rise_en && scnt == `VLH_RDY_SAMPLES - 2'h1) begin
              got <= 1'b1;
            end else if (scnt != `VLH_RDY_SAMPLES - 2'h1) begin
              scnt <= scnt + 2'h1;
            end
          end
          // Half a cycle after got is set at a rise sample read data are taken, RL13
          if (fall_en && got && !latched) begin
            latched <= 1'b1;
            if (rd) rdata <= din3;
          end
          if (rise_en) begin
            cyc <= cyc + 8'h01;
            if (latched && min_met) begin
              // Strobe released on the rise after the latch, RL13 RL11
              output_enable_n <= 1'b1;
              write_enable_n <= 1'b1;
              cyc <= 8'h00;
              moved <= 1'b0;
              if (beats != 8'h00) begin
                beats <= beats - 8'h01;
                state <= ST_GAP; // RL16
              end else begin
                state <= ST_HOLD;
              end
            end
          end
        end
        ST_GAP: begin
          // Address steps on the fall after the release; select stays low, RL16
          if (fall_en && !moved) begin
            moved <= 1'b1;
            bus_address <= bus_address + step[ADDR_W-1:0];
          end
          if (rise_en) begin
            if (cyc == {3'h0, gap_cnt}) begin
              // Strobe high for gap+1 cycles before the next beat, RL14
              output_enable_n <= ~rd;
              write_enable_n <= rd;
              cyc <= 8'h00;
              scnt <= 2'h0;
              got <= 1'b0;
              latched <= 1'b0;
              state <= ST_STROBE;
            end else begin
              cyc <= cyc + 8'h01;
            end
          end
        end
        ST_HOLD: begin
          // Select and lanes held one more cycle past the last release, RL15
          if (rise_en) begin
            device_select_n <= {NSEL{1'b1}};
            byte_lane_strobe_n <= 4'hf;
            bus_data_oe_n <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // vlh_host_port

// ==== test/vlh_host_port_sva.sv ====
// Protocol checker for the variable-latency host port, bound to its ports
`include "vlh_defines.vh"
module vlh_host_port_sva #(
  parameter ADDR_W = 26, // Bus address width
  parameter NSEL = 6, // Number of device selects
  parameter HALF_DIV = 2 // Reference cycles per half memory cycle
) (
  input logic ref_clk,
  input logic sys_rst,
  input logic [4:0] avs_address,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic avs_waitrequest,
  input logic [ADDR_W-1:0] bus_address,
  input logic bus_data_oe_n,
  input logic [NSEL-1:0] device_select_n,
  input logic [3:0] byte_lane_strobe_n,
  input logic output_enable_n,
  input logic write_enable_n,
  input logic ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MC = 2 * HALF_DIV; // Reference cycles per memory cycle
  localparam int OE_D = 2 * MC - 1; // Select to strobe, less the final cycle
  wire sel_any = ~&device_select_n; // Some device selected
  wire s_n = output_enable_n & write_enable_n; // Strobe idle
  logic [12:0] tim; // Shadow of the timing register
  logic [15:0] lo_cnt, hi_cnt; // Strobe low and high run lengths
  logic rel; // A strobe was already released in this select
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Shadow timing writes so bounds follow what software set; writes while busy are not made
  always @(posedge ref_clk) begin
    if (sys_rst) tim <= `VLH_TIMING_RST;
    else if (avs_write && !avs_waitrequest && avs_address == `VLH_REG_TIMING)
      tim <= avs_writedata[12:0];
    lo_cnt <= s_n ? 16'h0 : lo_cnt + 16'h1;
    hi_cnt <= (s_n && !sys_rst) ? hi_cnt + 16'h1 : 16'h0;
    rel <= sel_any && (rel || $rose(s_n));
  end
  sequence s_release;
    $rose(s_n);
  endsequence
  sequence s_first_strobe;
    ##OE_D s_n ##1 !s_n;
  endsequence
  chk_one_select: assert property ($onehot0(~device_select_n))
    else $error("more than one device select low");
  chk_oe_delay: assert property ($rose(sel_any) |-> s_first_strobe)
    else $error("strobe not two memory cycles after select");
  chk_read_dir: assert property (!output_enable_n |-> write_enable_n && bus_data_oe_n)
    else $error("read strobe with write strobe or data drive");
  chk_strobe_lanes: assert property (!s_n |-> sel_any && !(&byte_lane_strobe_n))
    else $error("strobe without select or lanes");
  chk_min_strobe: assert property (s_release |-> lo_cnt >= MC * (tim[4:0] + 1))
    else $error("strobe shorter than first count plus one");
  chk_gap_len: assert property (rel && $fell(s_n) |-> hi_cnt >= MC * (tim[12:8] + 1))
    else $error("beat gap shorter than gap count plus one");
  // Holds for every legal divider, as one memory cycle is at least four cycles
  chk_sel_hold: assert property (s_release |-> (sel_any && !(&byte_lane_strobe_n))[*4])
    else $error("select or lanes dropped too early");
  chk_addr_steady: assert property (!s_n && !$past(s_n) |-> $stable(bus_address))
    else $error("address moved under strobe");
  chk_ready_gate: assert property (s_release and ~&device_select_n[5:3] |-> !$past(ready_n, 4))
    else $error("strobe released without ready");
endmodule // vlh_host_port_sva

bind vlh_host_port vlh_host_port_sva #(.ADDR_W(ADDR_W), .NSEL(NSEL), .HALF_DIV(HALF_DIV)) u_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .bus_address(bus_address), .bus_data_oe_n(bus_data_oe_n), .device_select_n(device_select_n),
  .byte_lane_strobe_n(byte_lane_strobe_n), .output_enable_n(output_enable_n),
  .write_enable_n(write_enable_n), .ready_n(ready_n)
);

// ==== test/vlh_dev_model.sv ====
// Behavioural display controller port: wait stretching, register and buffer spaces
module vlh_dev_model #(
  parameter WAIT_HI = 1 // Wait polarity strap: 1 = wait active high
) (
  input wire logic ref_clk,
  input wire logic [5:0] device_select_n,
  input wire logic [25:0] bus_address,
  input wire logic [31:0] bus_data_out,
  input wire logic [3:0] byte_lane_strobe_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [15:0] lat,
  output logic ready_n,
  output logic [31:0] bus_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [0:15]; // Register space
  logic [31:0] bufm [0:15]; // Display buffer space
  logic [15:0] cnt = 16'h0; // Cycles since the strobe fell
  logic wt = 1'b1; // Wait, raised while idle so no early ready is seen
  logic [3:0] lane_seen = 4'hf; // Lanes at the last strobe
  logic [5:0] sel_seen = 6'h3f; // Selects at the last strobe
  int nbeat = 0; // Strobes seen
  wire stb = ~&device_select_n & ~(output_enable_n & write_enable_n);
  wire [3:0] ix = bus_address[5:2];
  assign ready_n = WAIT_HI ? wt : !wt;
  initial bus_data_in = 32'h0;
  // Stretch each access by lat cycles, then hold ready and data until release
  always @(posedge ref_clk) begin
    cnt <= stb ? cnt + 16'h1 : 16'h0;
    wt <= !(stb && cnt >= lat);
    if (stb && cnt == 16'h0) begin
      lane_seen <= byte_lane_strobe_n;
      sel_seen <= device_select_n;
      nbeat <= nbeat + 1;
    end
    if (stb && !write_enable_n && !wt && bus_address[21]) bufm[ix] <= bus_data_out;
    if (stb && !write_enable_n && !wt && !bus_address[21]) regs[ix] <= bus_data_out;
    // A released bus shows the inverse of its last value, never a stale copy
    bus_data_in <= (stb && !output_enable_n) ? (bus_address[21] ? bufm[ix] : regs[ix]) : ~bus_data_in;
  end
endmodule // vlh_dev_model

// ==== test/tb_vlh_host_port.sv ====
// Self-checking bench: host port against the behavioural device model
`include "vlh_defines.vh"
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end \
end
module tb_vlh_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, bus_data_out, bus_data_in, q, s;
  logic avs_waitrequest, bus_data_oe_n, output_enable_n, write_enable_n, ready_n, host_port_clock;
  logic [25:0] bus_address;
  logic [5:0] device_select_n;
  logic [3:0] byte_lane_strobe_n;
  logic [15:0] lat = 16'h1e; // Device stretch in clock cycles
  int error_cnt = 0, checked = 0;
  always #4 ref_clk = ~ref_clk;
  vlh_host_port uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .host_port_clock(host_port_clock),
    .bus_address(bus_address), .bus_data_out(bus_data_out), .bus_data_in(bus_data_in),
    .bus_data_oe_n(bus_data_oe_n), .device_select_n(device_select_n),
    .byte_lane_strobe_n(byte_lane_strobe_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .ready_n(ready_n));
  vlh_dev_model u_dev (.ref_clk(ref_clk), .device_select_n(device_select_n),
    .bus_address(bus_address), .bus_data_out(bus_data_out),
    .byte_lane_strobe_n(byte_lane_strobe_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .lat(lat), .ready_n(ready_n), .bus_data_in(bus_data_in));
  // One Avalon cycle, held until waitrequest is sampled low; read data lands in q
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) error_cnt++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  function automatic logic [15:0] ctl(logic rd, logic [2:0] sl, logic [1:0] sz, logic bg,
    logic [7:0] bl);
    return {bl, bg, sz, sl, rd, 1'b1};
  endfunction
  // Set address and data, order a transfer, poll until done or error, fetch read data
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic [15:0] c);
    int n;
    n = 0;
    bus(1'b1, `VLH_REG_ADDR, a);
    bus(1'b1, `VLH_REG_WDATA, d);
    bus(1'b1, `VLH_REG_CTRL, {16'h0, c});
    s = 32'h0;
    while (s[2:1] === 2'b00 && n < 200) begin
      bus(1'b0, `VLH_REG_STATUS, 32'h0);
      s = q;
      n++;
    end
    if (n >= 200) error_cnt++;
    bus(1'b1, `VLH_REG_STATUS, 32'h6);
    bus(1'b0, `VLH_REG_RDATA, 32'h0);
  endtask
  // The memory clock period must not drop below what the device port can take
  task automatic t_clock;
    time t0;
    @(posedge host_port_clock);
    t0 = $time;
    @(posedge host_port_clock);
    `CHK("clock limit", 1'b1, ($time - t0) >= 64'd20)
    $display("t_clock done");
  endtask
  // Register and buffer spaces through a slow, ready-stretched select
  task automatic t_space;
    xfer(32'h0020_0008, 32'h0000_beef, ctl(1'b0, 3'h4, `VLH_SIZE_WORD, 1'b0, 8'h0));
    xfer(32'h0000_0008, 32'h0000_1234, ctl(1'b0, 3'h4, `VLH_SIZE_WORD, 1'b0, 8'h0));
    `CHK("status", 32'h2, s)
    xfer(32'h0020_0008, 32'h0, ctl(1'b1, 3'h4, `VLH_SIZE_WORD, 1'b0, 8'h0));
    `CHK("buffer", 32'hbeef_beef, q)
    xfer(32'h0000_0008, 32'h0, ctl(1'b1, 3'h4, `VLH_SIZE_WORD, 1'b0, 8'h0));
    `CHK("register", 32'h1234_1234, q)
    $display("t_space done");
  endtask
  // Lane encodings for byte, mirrored byte, word and dword on a 32-bit select
  task automatic t_lanes;
    logic [3:0] ex [4];
    logic [1:0] sz [4];
    ex = '{4'hd, 4'hb, 4'hc, 4'h0};
    sz = '{`VLH_SIZE_BYTE, `VLH_SIZE_BYTE, `VLH_SIZE_WORD, `VLH_SIZE_DWORD};
    lat <= 16'h4;
    bus(1'b1, `VLH_REG_WIDTH, 32'h10);
    for (int i = 0; i < 4; i++) begin
      xfer({30'h0, i < 2 ? 2'h1 : 2'h0}, 32'h0, ctl(1'b0, 3'h4, sz[i], i == 1, 8'h0));
      `CHK("lanes", ex[i], u_dev.lane_seen)
      `CHK("select", 6'h2f, u_dev.sel_seen)
    end
    bus(1'b1, `VLH_REG_WIDTH, 32'h0);
    $display("t_lanes done");
  endtask
  // Missing select, bad size and dword on a 16-bit select are refused with no strobe
  task automatic t_refuse;
    logic [15:0] bad [3];
    int b;
    bad = '{ctl(1'b0, 3'h6, `VLH_SIZE_WORD, 1'b0, 8'h0), ctl(1'b0, 3'h4, 2'h3, 1'b0, 8'h0),
      ctl(1'b0, 3'h3, `VLH_SIZE_DWORD, 1'b0, 8'h0)};
    for (int i = 0; i < 3; i++) begin
      b = u_dev.nbeat;
      xfer(32'h0, 32'h0, bad[i]);
      `CHK("error", 32'h4, s)
      `CHK("quiet", b, u_dev.nbeat)
    end
    $display("t_refuse done");
  endtask
  // Three-beat burst with a long gap; the third beat lands two words further on
  task automatic t_burst;
    int b;
    bus(1'b0, `VLH_REG_TIMING, 32'h0);
    `CHK("timing", `VLH_TIMING_RST, q)
    bus(1'b0, 5'h1c, 32'h0);
    `CHK("unmapped", 32'h0, q)
    bus(1'b1, `VLH_REG_TIMING, 32'h0000_0302);
    b = u_dev.nbeat;
    xfer(32'h0020_0000, 32'h0000_55aa, ctl(1'b0, 3'h5, `VLH_SIZE_WORD, 1'b0, 8'h2));
    `CHK("beats", b + 3, u_dev.nbeat)
    xfer(32'h0020_0004, 32'h0, ctl(1'b1, 3'h5, `VLH_SIZE_WORD, 1'b0, 8'h0));
    `CHK("third beat", 32'h55aa_55aa, q)
    $display("t_burst done");
  endtask
  // A select without ready stretching finishes long before the device is ready
  task automatic t_noready;
    time t0;
    t0 = $time;
    lat <= 16'h01f4;
    xfer(32'h0020_0000, 32'h0, ctl(1'b1, 3'h1, `VLH_SIZE_WORD, 1'b0, 8'h0));
    `CHK("no wait", 1'b1, ($time - t0) < 64'd2000)
    $display("t_noready done");
  endtask
  task automatic results;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_clock;
    t_space;
    t_lanes;
    t_refuse;
    t_burst;
    t_noready;
    results;
  end
  // Watchdog well beyond the expected run of under ten microseconds
  initial begin
    #300us;
    error_cnt++;
    results;
  end
endmodule // tb_vlh_host_port
